/* include/conv_pkg.sv */
// Constants shared by the converter control block and its clock tick generator.
// Assumes a 20 MHz bus clock and a 32-bit AHB-Lite register bus.
package conv_pkg;
    // ****************************************************************
    // Register byte offsets.
    // ****************************************************************
    localparam logic [7:0] OFS_SC1  = 8'h00;
    localparam logic [7:0] OFS_SC2  = 8'h04;
    localparam logic [7:0] OFS_RES  = 8'h08;
    localparam logic [7:0] OFS_CV   = 8'h0c;
    localparam logic [7:0] OFS_CFG  = 8'h10;
    // ****************************************************************
    // Field positions and codes.
    // ****************************************************************
    localparam int SC1_FLAG   = 7;
    localparam int SC1_IEN    = 6;
    localparam int SC1_CONT   = 5;
    localparam int SC2_ACT    = 7;
    localparam int SC2_HWT    = 6;
    localparam int SC2_CMPEN  = 5;
    localparam int SC2_CMPGE  = 4;
    localparam int CFG_MODE8  = 2;
    localparam int CFG_DIV_LO = 5;
    localparam logic [4:0] CH_LAST_PIN = 5'h0f;
    localparam logic [4:0] CH_TEMP     = 5'h1a;
    localparam logic [4:0] CH_BGAP     = 5'h1b;
    localparam logic [4:0] CH_OFF      = 5'h1f;
    localparam logic [4:0] SC1_RESET   = 5'h1f;
    localparam logic [1:0] CLK_BUS     = 2'h0;
    localparam logic [1:0] CLK_HALF    = 2'h1;
    localparam logic [1:0] CLK_ALT     = 2'h2;
    localparam logic [1:0] CLK_LOCAL   = 2'h3;
    localparam int RES_BITS = 10;
    localparam int RES8_BITS = 8;
    localparam int CH_BITS = 5;
    localparam int SAMPLE_CYC = 2;
endpackage : conv_pkg

/* design/edge_pulse_sync.sv */
// Two-flop synchroniser followed by a rising-edge detector.
// Assumes the input is asynchronous to clk and stable for two clocks.
`timescale 1ns/1ns
module edge_pulse_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Signal.
    input  wire logic async_in,
    output logic      rise_pulse
);
    logic meta_reg, sync_reg, last_reg;
    logic meta_next, sync_next, last_next;
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
        last_next = sync_reg;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end
    // One pulse per rising edge, so one overflow never starts two conversions.
    assign rise_pulse = sync_reg & ~last_reg;
endmodule : edge_pulse_sync

/* design/conv_tick_gen.sv */
// Conversion clock tick generator: picks a source and divides it.
// Assumes asynchronous sources are at most half the bus clock rate.
`timescale 1ns/1ns
module conv_tick_gen (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Sources.
    input  wire logic       local_async_conv_clock,
    input  wire logic       alternate_conv_clock,
    // Control.
    input  wire logic [1:0] src_sel,
    input  wire logic [1:0] clock_divide_field,
    output logic            conv_tick
);
    import conv_pkg::*;
    logic alt_rise, loc_rise, src_tick;
    logic half_reg, half_next;
    logic [2:0] div_reg, div_next;
    logic [2:0] div_max;
    edge_pulse_sync u_alt (.clk(clk), .rst_b(rst_b), .async_in(alternate_conv_clock),
                           .rise_pulse(alt_rise));
    edge_pulse_sync u_loc (.clk(clk), .rst_b(rst_b), .async_in(local_async_conv_clock),
                           .rise_pulse(loc_rise));
    always_comb begin
        half_next = ~half_reg;
        unique case (src_sel)
            CLK_BUS:  src_tick = 1'b1;
            CLK_HALF: src_tick = half_reg;
            CLK_ALT:  src_tick = alt_rise;
            CLK_LOCAL: src_tick = loc_rise;
        endcase
        div_max = 3'((3'h1 << clock_divide_field) - 3'h1);
        div_next = div_reg;
        if (src_tick)
            div_next = (div_reg >= div_max) ? 3'h0 : 3'(div_reg + 3'h1);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_reg <= 1'b0;
            div_reg  <= 3'h0;
        end else begin
            half_reg <= half_next;
            div_reg  <= div_next;
        end
    end
    assign conv_tick = src_tick && (div_reg >= div_max);
endmodule : conv_tick_gen

/* design/adc_conversion_control.sv */
// Control logic of a 10-bit successive approximation converter.
// Assumes an AHB-Lite master, an analog comparator output and an RTC overflow level.
// Operation
// - Codes 00000..01111 route external pins 0..15 to the converter.
// - Reserved channel codes give an undefined result.
// - Code 11010 selects the temperature sensor.
// - Code 11011 selects the bandgap reference.
// - Up to 28 channels selectable through the channel field.
// - Conversion clock from bus, bus halved, local async or alternate clock.
// - Alternate clock comes from the external reference clock.
// - Selected source divided by the clock divide field.
// - Alternate clock keeps converting while the processor waits.
// - With hardware trigger on, each counter overflow while idle starts one conversion.
// - Overflow triggers regardless of the counter interrupt enable.
// - Trigger path works in run, wait and shallow stop.
// - Linear successive approximation with 10 bits resolution.
// - Result right-justified, 10-bit or 8-bit format.
// - Single or continuous conversion; single returns to idle alone.
// - Completion flag set at end, with interrupt.
// - Compare result less-than or greater-or-equal, interrupt when true.
// - Channel code all ones switches the converter off.
// - Writing the first control register aborts and restarts unless all ones; with hardware trigger on it only stops on all ones.
`timescale 1ns/1ns
module adc_conversion_control #(
    parameter int NUM_PINS = 16
) (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // AHB-Lite slave.
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic [31:0]                      hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // Clock sources and trigger.
    input  wire logic                        local_async_conv_clock,
    input  wire logic                        external_reference_clock,
    input  wire logic                        hardware_conversion_trigger,
    // Analog front end.
    input  wire logic                        comparator_out,
    output logic [conv_pkg::CH_BITS-1:0]     mux_select,
    output logic                             mux_enable,
    output logic                             sample_hold,
    output logic [conv_pkg::RES_BITS-1:0]    dac_code,
    // Interrupt request.
    output logic                             conv_irq
);
    import conv_pkg::*;

    // ****************************************************************
    // State and registers.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b100
    } conv_state_e;

    conv_state_e state_reg, state_next;
    logic [4:0]  channel_select_field_reg, channel_select_field_next;
    logic        ien_reg, ien_next, cont_reg, cont_next, flag_reg, flag_next;
    logic        hwt_reg, hwt_next, cmpen_reg, cmpen_next, cmpge_reg, cmpge_next;
    logic        mode8_reg, mode8_next;
    logic [1:0]  src_reg, src_next, div_reg, div_next;
    logic [RES_BITS-1:0] cv_reg, cv_next, res_reg, res_next, sar_reg, sar_next;
    logic [RES_BITS-1:0] bit_reg, bit_next;
    logic [1:0]  samp_reg, samp_next;
    logic        wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
    logic [7:0]  addr_reg, addr_next;
    logic [31:0] hrdata_reg, hrdata_next;

    logic trig_pulse, conv_tick, bus_take, sc1_write, res_read, start_req, cmp_true;
    logic [RES_BITS-1:0] final_code;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    edge_pulse_sync u_trig (
        .clk        (clk),
        .rst_b      (rst_b),
        .async_in   (hardware_conversion_trigger),
        .rise_pulse (trig_pulse)
    );

    conv_tick_gen u_tick (
        .clk                    (clk),
        .rst_b                  (rst_b),
        .local_async_conv_clock (local_async_conv_clock),
        .alternate_conv_clock   (external_reference_clock),
        .src_sel                (src_reg),
        .clock_divide_field     (div_reg),
        .conv_tick              (conv_tick)
    );

    // ****************************************************************
    // Bus and conversion next-state logic.
    // ****************************************************************
    always_comb begin
        bus_take     = hsel && hready && htrans[1];
        wr_pend_next = bus_take && hwrite;
        rd_pend_next = bus_take && !hwrite;
        addr_next    = bus_take ? haddr[7:0] : addr_reg;
        sc1_write    = wr_pend_reg && (addr_reg == OFS_SC1);
        res_read     = rd_pend_reg && (addr_reg == OFS_RES);

        channel_select_field_next = channel_select_field_reg;
        ien_next   = ien_reg;
        cont_next  = cont_reg;
        hwt_next   = hwt_reg;
        cmpen_next = cmpen_reg;
        cmpge_next = cmpge_reg;
        mode8_next = mode8_reg;
        src_next   = src_reg;
        div_next   = div_reg;
        cv_next    = cv_reg;
        if (wr_pend_reg) begin
            unique case (addr_reg)
                OFS_SC1: begin
                    channel_select_field_next = hwdata[CH_BITS-1:0];
                    cont_next = hwdata[SC1_CONT];
                    ien_next  = hwdata[SC1_IEN];
                end
                OFS_SC2: begin
                    hwt_next   = hwdata[SC2_HWT];
                    cmpen_next = hwdata[SC2_CMPEN];
                    cmpge_next = hwdata[SC2_CMPGE];
                end
                OFS_CV:  cv_next = hwdata[RES_BITS-1:0];
                OFS_CFG: begin
                    src_next   = hwdata[1:0];
                    mode8_next = hwdata[CFG_MODE8];
                    div_next   = hwdata[CFG_DIV_LO+1:CFG_DIV_LO];
                end
                default: ;
            endcase
        end

        // Software writes start when trigger is off; the counter overflow otherwise.
        start_req = (sc1_write && !hwt_reg && hwdata[CH_BITS-1:0] != CH_OFF)
                  || (hwt_reg && trig_pulse && channel_select_field_reg != CH_OFF
                      && state_reg == ST_IDLE);

        final_code = sar_reg | ((comparator_out) ? bit_reg : '0);
        cmp_true   = cmpge_reg ? (final_code >= cv_reg) : (final_code < cv_reg);

        state_next = state_reg;
        sar_next  = sar_reg;
        bit_next  = bit_reg;
        samp_next = samp_reg;
        res_next  = res_reg;
        flag_next = flag_reg;
        if (sc1_write || res_read) flag_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: ;
            ST_SAMPLE: if (conv_tick) begin
                if (samp_reg == 2'(SAMPLE_CYC - 1)) state_next = ST_CONV;
                samp_next = 2'(samp_reg + 2'h1);
            end
            ST_CONV: if (conv_tick) begin
                sar_next = final_code;
                bit_next = bit_reg >> 1;
                if (bit_reg[0]) begin
                    if (!cmpen_reg || cmp_true) begin
                        res_next  = mode8_reg ? (final_code >> (RES_BITS - RES8_BITS))
                                              : final_code;
                        flag_next = 1'b1;
                    end
                    // Continuous restarts unless hardware triggered; single goes idle by itself.
                    if (cont_reg && !hwt_reg) begin
                        state_next = ST_SAMPLE;
                        sar_next = '0;
                        bit_next = {1'b1, {(RES_BITS-1){1'b0}}};
                        samp_next = 2'h0;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (start_req) begin
            state_next = ST_SAMPLE;
            sar_next   = '0;
            bit_next   = {1'b1, {(RES_BITS-1){1'b0}}};
            samp_next  = 2'h0;
        end
        // Off comes last so it wins over a running conversion and a trigger alike.
        if (sc1_write && hwdata[CH_BITS-1:0] == CH_OFF) state_next = ST_IDLE;

        hrdata_next = 32'h0;
        if (bus_take && !hwrite) begin
            unique case (haddr[7:0])
                OFS_SC1: hrdata_next = {24'h0, flag_reg, ien_reg, cont_reg,
                                        channel_select_field_reg};
                OFS_SC2: hrdata_next = {24'h0, state_reg != ST_IDLE, hwt_reg,
                                        cmpen_reg, cmpge_reg, 4'h0};
                OFS_RES: hrdata_next = {22'h0, res_reg};
                OFS_CV:  hrdata_next = {22'h0, cv_reg};
                OFS_CFG: hrdata_next = {24'h0, 1'b0, div_reg, 2'h0, mode8_reg, src_reg};
                default: hrdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            channel_select_field_reg <= SC1_RESET;
            ien_reg <= 1'b0;
            cont_reg <= 1'b0;
            flag_reg <= 1'b0;
            hwt_reg <= 1'b0;
            cmpen_reg <= 1'b0;
            cmpge_reg <= 1'b0;
            mode8_reg <= 1'b0;
            src_reg <= CLK_BUS;
            div_reg <= 2'h0;
            cv_reg <= '0;
            res_reg <= '0;
            sar_reg <= '0;
            bit_reg <= '0;
            samp_reg <= 2'h0;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h0;
            hrdata_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            channel_select_field_reg <= channel_select_field_next;
            ien_reg <= ien_next;
            cont_reg <= cont_next;
            flag_reg <= flag_next;
            hwt_reg <= hwt_next;
            cmpen_reg <= cmpen_next;
            cmpge_reg <= cmpge_next;
            mode8_reg <= mode8_next;
            src_reg <= src_next;
            div_reg <= div_next;
            cv_reg <= cv_next;
            res_reg <= res_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            samp_reg <= samp_next;
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Codes 0..15 pass straight to the pin mux; 26 and 27 reach sensor and
    // bandgap; reserved codes convert whatever the mux offers.
    assign mux_select = channel_select_field_reg;
    assign mux_enable = channel_select_field_reg != CH_OFF;
    assign sample_hold = state_reg == ST_SAMPLE;
    assign dac_code  = sar_reg | bit_reg;
    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign conv_irq  = flag_reg & ien_reg;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    flag_on_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_CONV && conv_tick && bit_reg[0] && !cmpen_reg && !start_req)
        |=> flag_reg) else $error("flag not set after conversion");
    single_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_CONV && conv_tick && bit_reg[0] && !cont_reg && !start_req)
        |=> state_reg == ST_IDLE) else $error("single conversion did not go idle");
    off_stops_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sc1_write && hwdata[4:0] == CH_OFF) |=> state_reg == ST_IDLE)
        else $error("all-ones channel did not stop converter");
    write_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sc1_write && !hwt_reg && hwdata[4:0] != CH_OFF
         && !(state_reg == ST_CONV && conv_tick && bit_reg[0]))
        |=> state_reg == ST_SAMPLE && !flag_reg)
        else $error("write did not restart conversion");
    trig_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (hwt_reg && trig_pulse && state_reg == ST_IDLE && channel_select_field_reg != CH_OFF
         && !sc1_write) |=> state_reg == ST_SAMPLE) else $error("trigger did not start conversion");
    trig_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        trig_pulse |=> !trig_pulse) else $error("trigger pulse duplicated");
    result_eight_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode8_reg && $changed(res_reg) |-> res_reg[9:8] == 2'h0)
        else $error("8-bit result not right-justified");
    irq_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_CONV && conv_tick && bit_reg[0] && cmpen_reg && !cmp_true
         && !start_req && !sc1_write && !res_read) |=> flag_reg == $past(flag_reg))
        else $error("flag set though compare false");
    mux_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg != ST_IDLE |-> mux_enable && mux_select == channel_select_field_reg)
        else $error("channel routing mismatch");
endmodule : adc_conversion_control

/* tb/rtc_analog_model.sv */
// Far-side model: analog channel levels seen by the comparator, and a real-time counter.
// Assumes the converter drives its channel code and trial code straight into the comparator.
`timescale 1ns/1ns
module rtc_analog_model #(
    parameter int RTC_MOD = 200
) (
    // Converter side.
    input  wire logic       mux_enable,
    input  wire logic [4:0] mux_select,
    input  wire logic [9:0] dac_code,
    output logic            comparator_out,
    // Real-time counter.
    input  wire logic       external_reference_clock,
    input  wire logic       rtc_run,
    input  wire logic       rtc_interrupt_enable,
    output logic            hardware_conversion_trigger
);
    int cnt;
    // ****************************************************************
    // Channel levels.
    // ****************************************************************
    function automatic logic [9:0] level(input logic [4:0] ch);
        case (ch) inside
            [5'h00:5'h0f]: level = 10'h040 + 10'h025 * {5'h00, ch};
            [5'h10:5'h15], 5'h1e: level = 10'h000;
            5'h1a: level = 10'h1a5;
            5'h1b: level = 10'h0ea;
            5'h1d: level = 10'h3ff;
            default: level = 10'h155;
        endcase
    endfunction : level
    // The input sits half a step above its level, so an equal trial reads as below it.
    assign comparator_out = mux_enable && (level(mux_select) >= dac_code);
    // ****************************************************************
    // Counter overflow, blind to the interrupt enable on purpose.
    // ****************************************************************
    always @(posedge external_reference_clock or negedge rtc_run) begin
        if (!rtc_run) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == RTC_MOD - 1) ? 0 : cnt + 1;
        end
    end
    assign hardware_conversion_trigger = rtc_run && (cnt >= RTC_MOD - 2);
endmodule : rtc_analog_model

/* tb/adc_conversion_control_test.sv */
// Self-checking bench: AHB-Lite register traffic against the converter control block.
// Assumes the far-side model supplies comparator levels and counter overflows.
`timescale 1ns/1ns
module adc_conversion_control_test;
    import conv_pkg::*;
    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, comparator_out;
    logic        mux_enable, sample_hold, conv_irq, local_clk, ref_clk, trig, rtc_run, f;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  mux_select;
    logic [9:0]  dac_code;
    logic [4:0]  codes [9] = '{5'h00, 5'h01, 5'h08, 5'h0f, 5'h10, 5'h1a, 5'h1b, 5'h1d, 5'h16};
    int          fail_count = 0, cmp_count = 0, cyc = 0, t0, dur, lo, hi;
    // ****************************************************************
    // Clocks, design and model.
    // ****************************************************************
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        local_clk = 0;
        forever #65 local_clk = ~local_clk;
    end
    initial begin
        ref_clk = 0;
        #7;
        forever #85 ref_clk = ~ref_clk;
    end
    adc_conversion_control u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .local_async_conv_clock(local_clk),
        .external_reference_clock(ref_clk), .hardware_conversion_trigger(trig),
        .comparator_out(comparator_out), .mux_select(mux_select), .mux_enable(mux_enable),
        .sample_hold(sample_hold), .dac_code(dac_code), .conv_irq(conv_irq));
    rtc_analog_model u_model (.mux_enable(mux_enable), .mux_select(mux_select),
        .dac_code(dac_code), .comparator_out(comparator_out), .external_reference_clock(ref_clk),
        .rtc_run(rtc_run), .rtc_interrupt_enable(1'b0), .hardware_conversion_trigger(trig));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count = fail_count + 1;
            complete_run();
        end
    end
    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wait_flag(input int lim);
        f = 1'b0;
        repeat (lim) if (f === 1'b0) begin
            bus(1'b0, OFS_SC1, 32'h0);
            f = rd[SC1_FLAG];
        end
    endtask : wait_flag
    task automatic convert(input logic [4:0] ch, input logic m8, input logic chk);
        logic [9:0] lv;
        lv = u_model.level(ch);
        bus(1'b1, OFS_SC1, {27'h0, ch});
        t0 = cyc;
        wait_flag(200);
        dur = cyc - t0;
        check("flag", {31'h0, f}, 32'h1);
        check("mux_select", {27'h0, mux_select}, {27'h0, ch});
        bus(1'b0, OFS_RES, 32'h0);
        if (chk) check("result", rd, m8 ? {24'h0, lv[9:2]} : {22'h0, lv});
        bus(1'b0, OFS_SC2, 32'h0);
        check("active", {31'h0, rd[SC2_ACT]}, 32'h0);
    endtask : convert
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        rst_b = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        rtc_run = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        check("idle_code", {12'h0, dac_code, mux_select, mux_enable, conv_irq, hresp,
                            sample_hold, hreadyout}, 32'h3e1);
        bus(1'b0, OFS_SC1, 32'h0);
        check("sc1_reset", rd, {27'h0, SC1_RESET});
        $display("Test reset done");
        foreach (codes[i]) convert(codes[i], 1'b0, codes[i] != 5'h16);
        bus(1'b1, OFS_CFG, 32'h4);
        convert(5'h07, 1'b1, 1'b1);
        $display("Test channels done");
        // Slow and divided sources stretch the conversion by the selected ratio.
        // The divider runs free, so the first tick may come up to one period early.
        for (int s = 0; s < 4; s++) for (int c = 0; c < 4; c++) begin
            bus(1'b1, OFS_CFG, (c << 5) | s);
            convert(5'h06, 1'b0, 1'b1);
            lo = 11 * (1 << c) * ((s == 0) ? 1 : 2);
            hi = 12 * (1 << c) * ((s == 2) ? 4 : s + 1) + 40;
            check("conv_time", {31'h0, dur >= lo && dur <= hi}, 32'h1);
        end
        // Still on the local clock divided by eight: bandgap first, then the sensor.
        convert(5'h1b, 1'b0, 1'b1);
        convert(5'h1a, 1'b0, 1'b1);
        bus(1'b1, OFS_CFG, 32'h0);
        $display("Test clocks done");
        bus(1'b1, OFS_SC1, 32'h43);
        wait_flag(200);
        check("irq_set", {31'h0, conv_irq}, 32'h1);
        bus(1'b0, OFS_RES, 32'h0);
        @(posedge clk);
        check("irq_clear", {31'h0, conv_irq}, 32'h0);
        bus(1'b1, OFS_CV, {22'h0, u_model.level(5'h09)});
        bus(1'b1, OFS_SC2, 32'h30);
        convert(5'h09, 1'b0, 1'b1);
        bus(1'b1, OFS_SC2, 32'h20);
        bus(1'b1, OFS_SC1, 32'h09);
        wait_flag(40);
        check("lt_flag", {31'h0, f}, 32'h0);
        bus(1'b1, OFS_SC2, 32'h0);
        $display("Test flag and compare done");
        bus(1'b1, OFS_SC1, 32'h22);
        wait_flag(200);
        bus(1'b0, OFS_RES, 32'h0);
        wait_flag(200);
        check("cont_again", {31'h0, f}, 32'h1);
        bus(1'b1, OFS_SC1, 32'h1f);
        bus(1'b0, OFS_SC2, 32'h0);
        check("off", {30'h0, rd[SC2_ACT], mux_enable}, 32'h0);
        bus(1'b0, OFS_RES, 32'h0);
        wait_flag(40);
        check("off_flag", {31'h0, f}, 32'h0);
        bus(1'b1, OFS_CFG, 32'h62);
        bus(1'b0, OFS_CFG, 32'h0);
        check("cfg_read", rd, 32'h62);
        bus(1'b1, OFS_SC1, 32'h04);
        bus(1'b1, OFS_CFG, 32'h0);
        convert(5'h0c, 1'b0, 1'b1);
        $display("Test continuous and abort done");
        bus(1'b1, OFS_SC2, 32'h40);
        bus(1'b1, OFS_SC1, 32'h05);
        wait_flag(30);
        check("no_sw_start", {31'h0, f}, 32'h0);
        rtc_run <= 1'b1;
        repeat (3) begin
            wait_flag(400);
            check("hw_flag", {31'h0, f}, 32'h1);
            bus(1'b0, OFS_RES, 32'h0);
            check("hw_result", rd, {22'h0, u_model.level(5'h05)});
            repeat (100) @(posedge clk);
            bus(1'b0, OFS_SC1, 32'h0);
            check("one_start", {31'h0, rd[SC1_FLAG]}, 32'h0);
        end
        $display("Test hardware trigger done");
        complete_run();
    end
endmodule : adc_conversion_control_test
